// ### core/boc_pkg.sv
package boc_pkg;

   // ************************************************************
   // Register indices; the bus byte address is four times the index.
   // ************************************************************
   localparam int unsigned BOC_IDX_WB_BUF1_ADDR0 = 12'h908;
   localparam int unsigned BOC_IDX_WB_BUF1_ADDR1 = 12'h909;
   localparam int unsigned BOC_IDX_WB_BUF1_ADDR2 = 12'h90A;
   localparam int unsigned BOC_IDX_WB_BUF1_ADDR3 = 12'h90B;
   localparam int unsigned BOC_IDX_SCRATCH0 = 12'h90C;
   localparam int unsigned BOC_IDX_SCRATCH1 = 12'h90D;
   localparam int unsigned BOC_IDX_SCRATCH2 = 12'h90E;
   localparam int unsigned BOC_IDX_SECOND_CTRL = 12'h920;
   localparam int unsigned BOC_IDX_OVERLAY_CTRL = 12'h930;
   localparam int unsigned BOC_IDX_PRIMARY_CTRL = 12'h940;
   localparam int unsigned BOC_IDX_FETCH_STATUS = 12'h941;
   localparam int unsigned BOC_ADDR_W = 14;

   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam logic [7:0] BOC_RST_WB_BUF1_ADDR0 = 8'h00;
   localparam logic [7:0] BOC_RST_WB_BUF1_ADDR1 = 8'h00;
   localparam logic [7:0] BOC_RST_WB_BUF1_ADDR2 = 8'h00;
   localparam logic [7:0] BOC_RST_WB_BUF1_ADDR3 = 8'h10;
   localparam logic [7:0] BOC_RST_SCRATCH0 = 8'h40;
   localparam logic [7:0] BOC_RST_SCRATCH1 = 8'h00;
   localparam logic [7:0] BOC_RST_SCRATCH2 = 8'h00;
   localparam logic [7:0] BOC_RST_SECOND_CTRL = 8'h00;
   localparam logic [7:0] BOC_RST_OVERLAY_CTRL = 8'h00;
   localparam logic [7:0] BOC_RST_PRIMARY_CTRL = 8'h00;

   // ************************************************************
   // Field positions.
   // ************************************************************
   localparam int unsigned BOC_BIT_ENABLE = 0;
   localparam int unsigned BOC_BIT_BLANK = 0;
   localparam int unsigned BOC_BIT_FETCH_TILED = 1;
   localparam int unsigned BOC_BIT_FMT_LO = 2;
   localparam int unsigned BOC_BIT_VFLIP = 5;
   localparam int unsigned BOC_BIT_HFLIP = 6;
   localparam int unsigned BOC_BIT_LINE_DBL = 7;
   localparam logic [7:0] BOC_MASK_SINGLE = 8'h01;
   localparam logic [7:0] BOC_MASK_PRIMARY = 8'hEF;

   // ************************************************************
   // Pixel formats and responses.
   // ************************************************************
   localparam logic [1:0] BOC_FMT_RGB332 = 2'h0;
   localparam logic [1:0] BOC_FMT_RGB565 = 2'h1;
   localparam logic [1:0] BOC_FMT_RGB888 = 2'h2;
   localparam logic [1:0] BOC_RESP_OKAY = 2'h0;
   localparam logic [1:0] BOC_RESP_SLVERR = 2'h2;
   localparam int unsigned BOC_NUM_REGS = 10;

endpackage

// ### core/boc_reg_if.sv
`timescale 1ns/1ps
// Write and read strobes between the bus slave and the register store.
interface boc_reg_if;
   logic [3:0] wr_sel;
   logic wr_en;
   logic [7:0] wr_data;
   logic [3:0] rd_sel;
   logic [7:0] rd_data;
   modport master (output wr_sel, output wr_en, output wr_data, output rd_sel, input rd_data);
   modport store (input wr_sel, input wr_en, input wr_data, input rd_sel, output rd_data);
endinterface

// ### core/boc_reg_store.sv
`timescale 1ns/1ps
// ************************************************************
// Byte register store with reset values and registered read data.
// ************************************************************
module boc_reg_store
   import boc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Access port.
   boc_reg_if.store port,
   // Register contents.
   output logic [7:0] regs_o [BOC_NUM_REGS]
);

   // Reset values and writable bits per entry.
   localparam logic [7:0] RST_TAB [BOC_NUM_REGS] = '{
      BOC_RST_WB_BUF1_ADDR0, BOC_RST_WB_BUF1_ADDR1, BOC_RST_WB_BUF1_ADDR2,
      BOC_RST_WB_BUF1_ADDR3, BOC_RST_SCRATCH0, BOC_RST_SCRATCH1, BOC_RST_SCRATCH2,
      BOC_RST_SECOND_CTRL, BOC_RST_OVERLAY_CTRL, BOC_RST_PRIMARY_CTRL};
   localparam logic [7:0] MASK_TAB [BOC_NUM_REGS] = '{
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      BOC_MASK_SINGLE, BOC_MASK_SINGLE, BOC_MASK_PRIMARY};

   logic [7:0] rd_data_q;

   // One entry per register; reserved bits never store a one.
   genvar gi;
   generate
      for (gi = 0; gi < BOC_NUM_REGS; gi++) begin : g_reg
         logic [7:0] val_q;
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               val_q <= RST_TAB[gi];
            end else if (port.wr_en && port.wr_sel == 4'(gi)) begin
               val_q <= port.wr_data & MASK_TAB[gi]; // RQ11
            end
         end
         assign regs_o[gi] = val_q;
      end
   endgenerate

   // Read data leaves through a flop; unknown selects read zero.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_data_q <= 8'h00;
      end else if (port.rd_sel < 4'(BOC_NUM_REGS)) begin
         rd_data_q <= regs_o[port.rd_sel]; // RQ11
      end else begin
         rd_data_q <= 8'h00;
      end
   end
   assign port.rd_data = rd_data_q;

endmodule

// ### core/boc_top.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Second output channel control bit 0 enables that output.
// RQ2 - Software stops frame control, waits one frame, then disables second output.
// RQ3 - Overlay output control bit 0 enables the overlay output.
// RQ4 - Software stops overlay frame control, waits one frame, then disables overlay.
// RQ5 - Primary bit 6 flips horizontally, bit 5 flips vertically.
// RQ6 - Format bits 3-2: 8bpp 332, 16bpp 565, 24bpp 888, 11 reserved.
// RQ7 - Fetch mode bit 1: zero line-by-line, one tiled frame.
// RQ8 - Tiled fetch needs widths multiple of 8 pixels and no flips.
// RQ9 - Blank bit replaces primary image with blank colour.
// RQ10 - Line doubling reads every image line twice from memory.
// RQ11 - Scratchpad registers store and return values, affect nothing else.
module boc_top
   import boc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // AXI4-Lite write address and data.
   input wire logic [BOC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [BOC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Configuration to the blending engine.
   output logic [31:0] wb_buf1_addr,
   output logic second_output_channel_en,
   output logic overlay_output_channel_en,
   output logic main_hflip,
   output logic main_vflip,
   output logic [1:0] main_pixel_format,
   output logic main_fmt_reserved,
   output logic [4:0] main_bytes_per_pixel,
   output logic main_fetch_tiled,
   output logic main_line_double,
   output logic main_blank,
   // Fetcher line tracking.
   input wire logic fetch_line_done,
   input wire logic fetch_frame_start,
   output logic fetch_repeat_line,
   output logic fetch_tiled_conflict
);

   // ************************************************************
   // Write and read channel state.
   // ************************************************************
   typedef enum logic [1:0] {BOC_WR_IDLE, BOC_WR_RESP} boc_wr_e;
   typedef enum logic [1:0] {BOC_RD_IDLE, BOC_RD_WAIT, BOC_RD_RESP} boc_rd_e;

   boc_wr_e wr_state_q;
   boc_rd_e rd_state_q;
   logic aw_have_q;
   logic w_have_q;
   logic [BOC_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [BOC_ADDR_W-1:0] araddr_q;
   logic [7:0] regs [BOC_NUM_REGS];
   logic repeat_q;

   boc_reg_if rif ();

   boc_reg_store u_store (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .port(rif.store),
      .regs_o(regs)
   );

   // ************************************************************
   // Address decode.
   // ************************************************************
   function automatic logic [3:0] boc_decode(input logic [BOC_ADDR_W-1:0] a);
      logic [3:0] sel;
      sel = 4'hF;
      case (32'(a))
         BOC_IDX_WB_BUF1_ADDR0: sel = 4'h0;
         BOC_IDX_WB_BUF1_ADDR1: sel = 4'h1;
         BOC_IDX_WB_BUF1_ADDR2: sel = 4'h2;
         BOC_IDX_WB_BUF1_ADDR3: sel = 4'h3;
         BOC_IDX_SCRATCH0: sel = 4'h4;
         BOC_IDX_SCRATCH1: sel = 4'h5;
         BOC_IDX_SCRATCH2: sel = 4'h6;
         BOC_IDX_SECOND_CTRL: sel = 4'h7;
         BOC_IDX_OVERLAY_CTRL: sel = 4'h8;
         BOC_IDX_PRIMARY_CTRL: sel = 4'h9;
         BOC_IDX_FETCH_STATUS: sel = 4'hA;
         default: sel = 4'hF;
      endcase
      return sel;
   endfunction

   // Registers are byte wide, each at its own word: offsets are not all
   // multiples of four, so the byte address is four times the printed offset.
   wire logic [BOC_ADDR_W-1:0] aw_idx = BOC_ADDR_W'(awaddr_q >> 2);
   wire logic [BOC_ADDR_W-1:0] ar_idx = BOC_ADDR_W'(araddr_q >> 2);
   wire logic [3:0] wr_sel = boc_decode(aw_idx);
   wire logic [3:0] rd_sel = boc_decode(ar_idx);
   wire logic [3:0] ar_in_sel = boc_decode(BOC_ADDR_W'(s_axi_araddr >> 2));
   wire logic wr_hit = (wr_sel < 4'(BOC_NUM_REGS));
   wire logic wr_fire = (wr_state_q == BOC_WR_IDLE) && aw_have_q && w_have_q;

   assign rif.wr_sel = wr_sel;
   assign rif.wr_data = wdata_q[7:0];
   assign rif.wr_en = wr_fire && wr_hit && wstrb_q[0];
   // The store is addressed from the incoming read address, so its output flop
   // already holds the word in the wait cycle after the address is taken.
   assign rif.rd_sel = ar_in_sel;

   // Ready while the holding slot is empty and no response is pending.
   assign s_axi_awready = !aw_have_q && (wr_state_q == BOC_WR_IDLE);
   assign s_axi_wready = !w_have_q && (wr_state_q == BOC_WR_IDLE);
   assign s_axi_bvalid = (wr_state_q == BOC_WR_RESP);
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = (rd_state_q == BOC_RD_IDLE);
   assign s_axi_rvalid = (rd_state_q == BOC_RD_RESP);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ************************************************************
   // Write path: address and data may arrive in either order.
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Response: unmapped or read-only targets answer SLVERR.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_state_q <= BOC_WR_IDLE;
         bresp_q <= BOC_RESP_OKAY;
      end else begin
         case (wr_state_q)
            BOC_WR_IDLE: begin
               if (wr_fire) begin
                  wr_state_q <= BOC_WR_RESP;
                  bresp_q <= wr_hit ? BOC_RESP_OKAY : BOC_RESP_SLVERR;
               end
            end
            BOC_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_q <= BOC_WR_IDLE;
               end
            end
            default: wr_state_q <= BOC_WR_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Read path: one wait cycle for the store's registered data.
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rd_state_q <= BOC_RD_IDLE;
         araddr_q <= '0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= BOC_RESP_OKAY;
      end else begin
         case (rd_state_q)
            BOC_RD_IDLE: begin
               if (s_axi_arvalid) begin
                  araddr_q <= s_axi_araddr;
                  rd_state_q <= BOC_RD_WAIT;
               end
            end
            BOC_RD_WAIT: begin
               rd_state_q <= BOC_RD_RESP;
               if (rd_sel == 4'hA) begin
                  rdata_q <= {30'h0000_0000, fetch_tiled_conflict, repeat_q};
                  rresp_q <= BOC_RESP_OKAY;
               end else begin
                  rdata_q <= {24'h00_0000, rif.rd_data};
                  rresp_q <= (rd_sel == 4'hF) ? BOC_RESP_SLVERR : BOC_RESP_OKAY;
               end
            end
            BOC_RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state_q <= BOC_RD_IDLE;
               end
            end
            default: rd_state_q <= BOC_RD_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Configuration decode to the engine.
   // ************************************************************
   assign wb_buf1_addr = {regs[3], regs[2], regs[1], regs[0]};
   assign second_output_channel_en = regs[7][BOC_BIT_ENABLE]; // RQ1
   assign overlay_output_channel_en = regs[8][BOC_BIT_ENABLE]; // RQ3
   assign main_hflip = regs[9][BOC_BIT_HFLIP]; // RQ5
   assign main_vflip = regs[9][BOC_BIT_VFLIP]; // RQ5
   assign main_pixel_format = regs[9][BOC_BIT_FMT_LO +: 2]; // RQ6
   assign main_fetch_tiled = regs[9][BOC_BIT_FETCH_TILED]; // RQ7
   assign main_line_double = regs[9][BOC_BIT_LINE_DBL]; // RQ10
   assign main_blank = regs[9][BOC_BIT_BLANK]; // RQ9

   // Bytes per pixel for the fetcher; reserved code fetches nothing.
   wire logic fmt_332 = (main_pixel_format == BOC_FMT_RGB332);
   wire logic fmt_565 = (main_pixel_format == BOC_FMT_RGB565);
   wire logic fmt_888 = (main_pixel_format == BOC_FMT_RGB888);
   assign main_fmt_reserved = !(fmt_332 || fmt_565 || fmt_888); // RQ6
   assign main_bytes_per_pixel = fmt_332 ? 5'h01 : fmt_565 ? 5'h02 : fmt_888 ? 5'h03 : 5'h00;

   // Software must not flip in tiled mode; flag it so it can be seen.
   assign fetch_tiled_conflict = main_fetch_tiled && (main_hflip || main_vflip); // RQ8

   // ************************************************************
   // Line doubling: alternate repeat and advance per fetched line.
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         repeat_q <= 1'b0;
      end else if (fetch_frame_start || !main_line_double) begin
         repeat_q <= 1'b0;
      end else if (fetch_line_done) begin
         repeat_q <= !repeat_q; // RQ10
      end
   end
   assign fetch_repeat_line = main_line_double && !repeat_q; // RQ10

endmodule

// ### verif/boc_monitor.sv
`timescale 1ns/1ps
// ************************************************************
// Port checker for the blending output configuration block.
// ************************************************************
module boc_monitor
   import boc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Bus handshakes.
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Configuration outputs.
   input wire logic second_output_channel_en,
   input wire logic overlay_output_channel_en,
   input wire logic main_hflip,
   input wire logic main_vflip,
   input wire logic [1:0] main_pixel_format,
   input wire logic main_fmt_reserved,
   input wire logic [4:0] main_bytes_per_pixel,
   input wire logic main_fetch_tiled,
   input wire logic main_line_double,
   // Fetcher tracking.
   input wire logic fetch_line_done,
   input wire logic fetch_frame_start,
   input wire logic fetch_repeat_line,
   input wire logic fetch_tiled_conflict
);
   // One clock domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // Decoded format and tiled-conflict outputs must follow their fields at all times.
   fmt_resv_a: assert property (main_fmt_reserved == (main_pixel_format == 2'h3))
      else $error("Reserved format flag disagrees with the format field.");
   bpp_map_a: assert property (main_bytes_per_pixel ==
      ((main_pixel_format == 2'h3) ? 5'h00 : {3'h0, main_pixel_format} + 5'h01))
      else $error("Bytes per pixel disagrees with the format field.");
   tile_flag_a: assert property (fetch_tiled_conflict ==
      (main_fetch_tiled && (main_hflip || main_vflip)))
      else $error("Tiled conflict flag is wrong.");
   // Enables and flips move only when a write completes, never on their own.
   second_hold_a: assert property ($changed(second_output_channel_en) |-> $rose(s_axi_bvalid))
      else $error("Second output enable changed without a write.");
   ovl_hold_a: assert property ($changed(overlay_output_channel_en) |-> $rose(s_axi_bvalid))
      else $error("Overlay output enable changed without a write.");
   flip_hold_a: assert property ($changed({main_hflip, main_vflip}) |-> $rose(s_axi_bvalid))
      else $error("Flip enables changed without a write.");
   // Read answers come two cycles after the address and wait for the master.
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("Read data did not arrive two cycles after the address.");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data dropped or changed while stalled.");
   // Each finished line without a frame start in the same cycle flips the repeat phase while doubling is on.
   dbl_tog_a: assert property (main_line_double && fetch_line_done && !fetch_frame_start |=>
      fetch_repeat_line != $past(fetch_repeat_line))
      else $error("Repeat phase did not toggle on a finished line.");
endmodule

bind boc_top boc_monitor u_boc_monitor (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .second_output_channel_en(second_output_channel_en),
   .overlay_output_channel_en(overlay_output_channel_en),
   .main_hflip(main_hflip),
   .main_vflip(main_vflip),
   .main_pixel_format(main_pixel_format),
   .main_fmt_reserved(main_fmt_reserved),
   .main_bytes_per_pixel(main_bytes_per_pixel),
   .main_fetch_tiled(main_fetch_tiled),
   .main_line_double(main_line_double),
   .fetch_line_done(fetch_line_done),
   .fetch_frame_start(fetch_frame_start),
   .fetch_repeat_line(fetch_repeat_line),
   .fetch_tiled_conflict(fetch_tiled_conflict)
);

// ### verif/tb_boc_top.sv
`timescale 1ns/1ps
module tb_boc_top;
   import boc_pkg::*;

   // ************************************************************
   // Signals, design and clock.
   // ************************************************************
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [BOC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, wb_buf1_addr;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic fetch_line_done = 1'b0, fetch_frame_start = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, main_pixel_format;
   logic second_output_channel_en, overlay_output_channel_en, main_hflip, main_vflip;
   logic main_fmt_reserved, main_fetch_tiled, main_line_double, main_blank;
   logic fetch_repeat_line, fetch_tiled_conflict;
   logic [4:0] main_bytes_per_pixel;
   int bad_count = 0;
   int cmp_count = 0;
   // Register table: offsets, reset values and readable bits.
   logic [11:0] offs [10] = '{12'h908, 12'h909, 12'h90A, 12'h90B, 12'h90C, 12'h90D,
      12'h90E, 12'h920, 12'h930, 12'h940};
   logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00};
   logic [7:0] mask [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h01,
      8'hEF};
   logic [4:0] bpp [4] = '{5'h01, 5'h02, 5'h03, 5'h00};
   logic [7:0] pats [4] = '{8'hFF, 8'h5A, 8'h00, 8'hA5};

   boc_top u_boc_top (.*);

   // Free-running system clock.
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   // ************************************************************
   // Checking and bus tasks.
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // A hang counts as a mismatch and ends the run at once.
   task automatic hang();
      bad_count++;
      conclude();
   endtask

   // Address and data go out together; each is dropped when taken.
   task automatic wr(input logic [11:0] off, input logic [7:0] d, input logic [1:0] er);
      int i;
      s_axi_awaddr <= {off, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            chk(s_axi_bresp, er);
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (i == 100) hang();
      @(posedge sys_clk);
   endtask

   // The stall count holds rready low for that many cycles of valid data.
   task automatic rd(input logic [11:0] off, input logic [7:0] e, input logic [1:0] er,
      input int st);
      int i;
      int k;
      k = 0;
      s_axi_araddr <= {off, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (st == 0);
      for (i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            chk(s_axi_rdata, {24'h0, e});
            chk(s_axi_rresp, er);
            s_axi_rready <= 1'b0;
            break;
         end
         if (s_axi_rvalid) begin
            k++;
            if (k >= st) s_axi_rready <= 1'b1;
         end
      end
      if (i == 100) hang();
      @(posedge sys_clk);
   endtask

   // One-cycle pulse on frame start or line done.
   task automatic pulse(input logic fs);
      if (fs) fetch_frame_start <= 1'b1;
      else fetch_line_done <= 1'b1;
      @(posedge sys_clk);
      fetch_frame_start <= 1'b0;
      fetch_line_done <= 1'b0;
      @(posedge sys_clk);
      @(posedge sys_clk);
   endtask

   // ************************************************************
   // Test sequence.
   // ************************************************************
   initial begin
      int j;
      int p;
      logic [7:0] v;
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      for (j = 0; j < 10; j++) rd(offs[j], rstv[j], BOC_RESP_OKAY, 0);
      chk(wb_buf1_addr, 32'h1000_0000);
      $display("Test reset values done");
      // Every pattern sets every register; the four patterns cover all four formats.
      for (p = 0; p < 4; p++) begin
         v = pats[p];
         for (j = 0; j < 10; j++) wr(offs[j], v, BOC_RESP_OKAY);
         for (j = 0; j < 10; j++) rd(offs[j], v & mask[j], BOC_RESP_OKAY, 0);
         chk(wb_buf1_addr, {v, v, v, v});
         chk({second_output_channel_en, overlay_output_channel_en}, {v[0], v[0]});
         chk({main_line_double, main_hflip, main_vflip}, v[7:5]);
         chk({main_pixel_format, main_fetch_tiled, main_blank}, v[3:0]);
         chk({main_fmt_reserved, main_bytes_per_pixel}, {&v[3:2], bpp[v[3:2]]});
         chk(fetch_tiled_conflict, v[1] & (v[6] | v[5]));
         wr(12'h90D, ~v, BOC_RESP_OKAY);
         chk(wb_buf1_addr, {v, v, v, v});
      end
      $display("Test register patterns done");
      wr(12'h940, 8'h80, BOC_RESP_OKAY);
      pulse(1'b1);
      chk(fetch_repeat_line, 32'h1);
      pulse(1'b0);
      chk(fetch_repeat_line, 32'h0);
      // The status word shows the repeat phase in bit 0.
      rd(12'h941, 8'h01, BOC_RESP_OKAY, 0);
      pulse(1'b0);
      chk(fetch_repeat_line, 32'h1);
      $display("Test line doubling done");
      // Frame control lives outside; a frame start stands for the one-frame wait.
      pulse(1'b1);
      wr(12'h920, 8'h00, BOC_RESP_OKAY);
      wr(12'h930, 8'h00, BOC_RESP_OKAY);
      chk({second_output_channel_en, overlay_output_channel_en}, 2'b00);
      wr(12'h920, 8'h01, BOC_RESP_OKAY);
      chk({second_output_channel_en, overlay_output_channel_en}, 2'b10);
      $display("Test output disable done");
      wr(12'h900, 8'h33, BOC_RESP_SLVERR);
      rd(12'h900, 8'h00, BOC_RESP_SLVERR, 0);
      wr(12'h941, 8'h01, BOC_RESP_SLVERR);
      s_axi_wstrb <= 4'h0;
      wr(12'h90E, 8'h77, BOC_RESP_OKAY);
      s_axi_wstrb <= 4'h1;
      rd(12'h90E, 8'hA5, BOC_RESP_OKAY, 0);
      rd(12'h90C, 8'hA5, BOC_RESP_OKAY, 3);
      $display("Test errors and stalls done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rd(12'h90B, 8'h10, BOC_RESP_OKAY, 0);
      rd(12'h940, 8'h00, BOC_RESP_OKAY, 0);
      chk({second_output_channel_en, overlay_output_channel_en}, 2'b00);
      $display("Test second reset done");
      conclude();
   end
endmodule
